// File: shared/bodc_pkg.sv
package bodc_pkg;
    // Register offsets
    localparam logic [7:0] BODC_ADDR_CTL = 8'ha3;
    localparam logic [7:0] BODC_ADDR_CTL2 = 8'hab;
    localparam logic [7:0] BODC_ADDR_TA = 8'hc7;
    // Timed access key bytes
    localparam logic [7:0] BODC_TA_KEY1 = 8'haa;
    localparam logic [7:0] BODC_TA_KEY2 = 8'h55;
    // Field positions in control and config bytes
    localparam int BODC_BIT_EN = 7;
    localparam int BODC_BIT_THR_HI = 5;
    localparam int BODC_BIT_THR_LO = 4;
    localparam int BODC_BIT_FLAG = 3;
    localparam int BODC_BIT_RSEL = 2;
    localparam int BODC_BIT_CAUSE = 1;
    localparam int BODC_BIT_LP_HI = 2;
    localparam int BODC_BIT_LP_LO = 1;
    localparam int BODC_BIT_FILT = 0;
    // Reset values of the second control register
    localparam logic [1:0] BODC_LP_RESET = 2'h0;
    localparam logic BODC_FILT_RESET = 1'b1;
    // Threshold codes
    localparam logic [1:0] BODC_THR_2V2 = 2'h3;
    localparam logic [1:0] BODC_THR_2V7 = 2'h2;
    localparam logic [1:0] BODC_THR_3V7 = 2'h1;
    localparam logic [1:0] BODC_THR_4V4 = 2'h0;
    // Low-power sampling codes
    localparam logic [1:0] BODC_LP_ALWAYS = 2'h0;
    localparam logic [1:0] BODC_LP_1M6 = 2'h1;
    localparam logic [1:0] BODC_LP_6M4 = 2'h2;
    localparam logic [1:0] BODC_LP_25M6 = 2'h3;
    // Timing: system clock and slow internal clock
    localparam int BODC_SYS_PERIOD_NS = 50;
    localparam int BODC_LOW_SPEED_INTERNAL_CLOCK_PERIOD_NS = 100000;
    localparam int BODC_LOW_SPEED_INTERNAL_CLOCK_DIV = BODC_LOW_SPEED_INTERNAL_CLOCK_PERIOD_NS / BODC_SYS_PERIOD_NS;
    localparam int BODC_SAMPLE_1M6_US = 1600;
    localparam int BODC_SAMPLE_6M4_US = 6400;
    localparam int BODC_SAMPLE_25M6_US = 25600;
    localparam int BODC_LOW_SPEED_INTERNAL_CLOCK_US = BODC_LOW_SPEED_INTERNAL_CLOCK_PERIOD_NS / 1000;
    localparam logic [7:0] BODC_PER_1M6 =
        8'(BODC_SAMPLE_1M6_US / BODC_LOW_SPEED_INTERNAL_CLOCK_US - 1);
    localparam logic [7:0] BODC_PER_6M4 =
        8'(BODC_SAMPLE_6M4_US / BODC_LOW_SPEED_INTERNAL_CLOCK_US - 1);
    localparam logic [7:0] BODC_PER_25M6 =
        8'(BODC_SAMPLE_25M6_US / BODC_LOW_SPEED_INTERNAL_CLOCK_US - 1);
    localparam logic [7:0] BODC_SAMPLE_TICKS = 8'h02;
    // Three ticks: the first may come at once, so two full periods pass
    localparam logic [1:0] BODC_SETTLE_TICKS = 2'h3;
    localparam logic [5:0] BODC_FILT_SYS_LAST = 6'h1f;
    localparam logic [5:0] BODC_FILT_LOW_SPEED_INTERNAL_CLOCK_LAST = 6'h01;
    // Timed access states
    typedef enum logic [1:0] {
        BODC_TA_IDLE = 2'b00,
        BODC_TA_HALF = 2'b01,
        BODC_TA_OPEN = 2'b10
    } bodc_ta_e;
endpackage

// File: design/bodc_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module bodc_sync2 (
    input wire logic i_clk_sys,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_q;

    // No reset: the level must survive a reset cycle for the flag preset
    always_ff @(posedge i_clk_sys) begin
        meta_q <= i_async;
        o_sync <= meta_q;
    end
endmodule
`default_nettype wire

// File: design/bodc_top.sv
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module bodc_top
    import bodc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_por,
    input wire logic i_cmp_low,
    input wire logic [7:0] i_cfg_byte,
    input wire logic i_sysclk_is_low_speed_internal_clock,
    input wire logic i_brownout_irq_enable,
    input wire logic i_global_irq_enable,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_irq,
    output logic o_bod_reset,
    output logic o_cmp_enable,
    output logic [1:0] o_threshold_select,
    output logic o_supply_low_status
);
    logic cmp_sync;
    logic [11:0] div_cnt_q;
    logic low_speed_internal_clock_tick;
    bodc_ta_e ta_q;
    logic wr_ctl;
    logic wr_ctl2;
    logic detector_enable_q;
    logic brownout_reset_select_q;
    logic brownout_event_flag_q;
    logic brownout_reset_cause_q;
    logic [1:0] lowpower_sampling_select_q;
    logic noise_filter_enable_q;
    logic [1:0] settle_cnt_q;
    logic valid_q;
    logic [7:0] period_cnt_q;
    logic [7:0] period_last;
    logic sample_q;
    logic src;
    logic use_low_speed_internal_clock_filter;
    logic [5:0] filt_cnt_q;
    logic [5:0] filt_last;
    logic filt_step;
    logic filt_q;
    logic low_now;
    logic low_prev_q;
    logic drop_ev;
    logic rise_ev;

    // Comparator output is asynchronous to the logic
    bodc_sync2 u_sync (
        .i_clk_sys(i_clk_sys),
        .i_async(i_cmp_low),
        .o_sync(cmp_sync)
    );

    // Slow internal clock as an enable pulse
    assign low_speed_internal_clock_tick = (div_cnt_q == 12'(BODC_LOW_SPEED_INTERNAL_CLOCK_DIV - 1));
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || low_speed_internal_clock_tick) begin
            div_cnt_q <= 12'h000;
        end else begin
            div_cnt_q <= div_cnt_q + 12'h001;
        end
    end

    // Timed access: any other write closes the window
    assign wr_ctl = i_wr && (ta_q == BODC_TA_OPEN) &&
        (i_addr == BODC_ADDR_CTL);
    assign wr_ctl2 = i_wr && (ta_q == BODC_TA_OPEN) &&
        (i_addr == BODC_ADDR_CTL2);
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ta_q <= BODC_TA_IDLE;
        end else if (i_wr) begin
            if (i_addr == BODC_ADDR_TA && i_wdata == BODC_TA_KEY1) begin
                ta_q <= BODC_TA_HALF;
            end else if (i_addr == BODC_ADDR_TA && i_wdata == BODC_TA_KEY2
                && ta_q == BODC_TA_HALF) begin
                ta_q <= BODC_TA_OPEN;
            end else begin
                ta_q <= BODC_TA_IDLE;
            end
        end
    end

    // Settings reloaded from the config byte on every reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            detector_enable_q <= i_cfg_byte[BODC_BIT_EN];
            o_threshold_select <=
                i_cfg_byte[BODC_BIT_THR_HI:BODC_BIT_THR_LO];
            brownout_reset_select_q <= i_cfg_byte[BODC_BIT_RSEL];
        end else if (wr_ctl) begin
            detector_enable_q <= i_wdata[BODC_BIT_EN];
            o_threshold_select <=
                i_wdata[BODC_BIT_THR_HI:BODC_BIT_THR_LO];
            brownout_reset_select_q <= i_wdata[BODC_BIT_RSEL];
        end
    end

    // Second control register: sampling mode and filter
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            lowpower_sampling_select_q <= BODC_LP_RESET;
            noise_filter_enable_q <= BODC_FILT_RESET;
        end else if (wr_ctl2) begin
            lowpower_sampling_select_q <=
                i_wdata[BODC_BIT_LP_HI:BODC_BIT_LP_LO];
            noise_filter_enable_q <= i_wdata[BODC_BIT_FILT];
        end
    end

    // Result invalid until the third slow tick after enabling
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !detector_enable_q) begin
            settle_cnt_q <= 2'h0;
            valid_q <= 1'b0;
        end else if (!valid_q && low_speed_internal_clock_tick) begin
            settle_cnt_q <= settle_cnt_q + 2'h1;
            valid_q <= (settle_cnt_q == BODC_SETTLE_TICKS - 2'h1);
        end
    end

    // Sampling period in slow ticks
    always_comb begin
        unique case (lowpower_sampling_select_q)
            BODC_LP_1M6: period_last = BODC_PER_1M6;
            BODC_LP_6M4: period_last = BODC_PER_6M4;
            BODC_LP_25M6: period_last = BODC_PER_25M6;
            BODC_LP_ALWAYS: period_last = 8'h00;
        endcase
    end

    // Comparator powered for a short window each period, or always in BODC_LP_ALWAYS mode
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            period_cnt_q <= 8'h00;
        end else if (low_speed_internal_clock_tick) begin
            if (period_cnt_q >= period_last) begin
                period_cnt_q <= 8'h00;
            end else begin
                period_cnt_q <= period_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_cmp_enable <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            o_cmp_enable <= detector_enable_q &&
                (lowpower_sampling_select_q == BODC_LP_ALWAYS ||
                period_cnt_q < BODC_SAMPLE_TICKS);
            // Sample at the end of the window, once the output settled
            if (low_speed_internal_clock_tick && period_cnt_q == BODC_SAMPLE_TICKS - 8'h01) begin
                sample_q <= cmp_sync;
            end
        end
    end

    assign src = (lowpower_sampling_select_q == BODC_LP_ALWAYS) ?
        cmp_sync : sample_q;

    // Fast filter only on a fast clock with comparator always on
    assign use_low_speed_internal_clock_filter = i_sysclk_is_low_speed_internal_clock ||
        lowpower_sampling_select_q != BODC_LP_ALWAYS;
    assign filt_last = use_low_speed_internal_clock_filter ?
        BODC_FILT_LOW_SPEED_INTERNAL_CLOCK_LAST : BODC_FILT_SYS_LAST;
    assign filt_step = use_low_speed_internal_clock_filter ? low_speed_internal_clock_tick : 1'b1;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            filt_q <= 1'b0;
            filt_cnt_q <= 6'h00;
        end else if (!noise_filter_enable_q) begin
            filt_q <= src;
            filt_cnt_q <= 6'h00;
        end else if (src == filt_q) begin
            filt_cnt_q <= 6'h00;
        end else if (filt_step) begin
            if (filt_cnt_q >= filt_last) begin
                filt_q <= src;
                filt_cnt_q <= 6'h00;
            end else begin
                filt_cnt_q <= filt_cnt_q + 6'h01;
            end
        end
    end

    // Crossings only count while the result is valid
    assign low_now = valid_q && filt_q;
    assign drop_ev = valid_q && low_now && !low_prev_q;
    assign rise_ev = valid_q && !low_now && low_prev_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            low_prev_q <= 1'b0;
            o_supply_low_status <= 1'b0;
        end else begin
            low_prev_q <= low_now;
            o_supply_low_status <= low_now;
        end
    end

    // Event flag: hardware set wins over a software clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            brownout_event_flag_q <= i_cfg_byte[BODC_BIT_EN] &&
                !i_cfg_byte[BODC_BIT_RSEL] && cmp_sync;
        end else if ((drop_ev && !brownout_reset_select_q) || rise_ev) begin
            brownout_event_flag_q <= 1'b1;
        end else if (wr_ctl && !i_wdata[BODC_BIT_FLAG]) begin
            brownout_event_flag_q <= 1'b0;
        end
    end

    // Interrupt request gated by both enables
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= brownout_event_flag_q && i_brownout_irq_enable &&
                i_global_irq_enable;
        end
    end

    // Reset held while supply low; our own reset then drops it
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_bod_reset <= 1'b0;
        end else begin
            o_bod_reset <= brownout_reset_select_q && low_now;
        end
    end

    // Cause flag survives every reset except power-on
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn && i_por) begin
            brownout_reset_cause_q <= 1'b0;
        end else if (o_bod_reset) begin
            brownout_reset_cause_q <= 1'b1;
        end else if (wr_ctl && !i_wdata[BODC_BIT_CAUSE]) begin
            brownout_reset_cause_q <= 1'b0;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !i_rd) begin
            o_rdata <= 8'h00;
        end else if (i_addr == BODC_ADDR_CTL) begin
            o_rdata <= {detector_enable_q, 1'b0, o_threshold_select,
                brownout_event_flag_q, brownout_reset_select_q,
                brownout_reset_cause_q, o_supply_low_status};
        end else if (i_addr == BODC_ADDR_CTL2) begin
            o_rdata <= {5'h00, lowpower_sampling_select_q,
                noise_filter_enable_q};
        end else begin
            o_rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    // Second key byte while the first is pending; gaps are legal
    sequence s_unlock;
        (ta_q == BODC_TA_HALF) ##0
        (i_wr && i_addr == BODC_ADDR_TA && i_wdata == BODC_TA_KEY2);
    endsequence

    sequence s_ctl_write;
        i_wr && i_addr == BODC_ADDR_CTL;
    endsequence

    a_unlock_open: assert property (
        s_unlock |=> ta_q == BODC_TA_OPEN)
        else $error("Key sequence did not open timed access");

    a_unlock_write: assert property (
        (ta_q == BODC_TA_OPEN) ##0 s_ctl_write |=>
        o_threshold_select == $past(i_wdata[5:4]))
        else $error("Unlocked control write not applied");

    a_locked_write: assert property (
        s_ctl_write ##0 (ta_q != BODC_TA_OPEN) |=>
        $stable(o_threshold_select) && $stable(detector_enable_q))
        else $error("Control changed without timed access");

    a_settle_hold: assert property (
        $rose(detector_enable_q) |-> ##1 !valid_q [*8])
        else $error("Result valid too soon after enable");

    a_flag_drop: assert property (
        drop_ev && !brownout_reset_select_q |=> brownout_event_flag_q)
        else $error("Drop did not set event flag");

    a_flag_rise: assert property (
        rise_ev |=> brownout_event_flag_q)
        else $error("Recovery did not set event flag");

    a_irq_gating: assert property (
        o_irq |-> $past(brownout_event_flag_q) &&
        $past(i_brownout_irq_enable) && $past(i_global_irq_enable))
        else $error("Interrupt without flag and enables");

    a_reset_on_drop: assert property (
        brownout_reset_select_q && low_now |=> o_bod_reset ##1
        brownout_reset_cause_q)
        else $error("Drop did not raise reset and cause");

    a_status_off: assert property (
        !detector_enable_q ##1 !detector_enable_q |=> !o_supply_low_status)
        else $error("Status high while detection disabled");

    a_filter_bypass: assert property (
        !noise_filter_enable_q |=> filt_q == $past(src))
        else $error("Disabled filter did not pass input");
endmodule
`default_nettype wire

// File: test/bodc_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
// Supply comparator: supply level against the selected trip level
module bodc_cmp_model (
    input wire logic i_clk_sys,
    input wire logic i_power,
    input wire logic [1:0] i_thr,
    input wire logic [12:0] i_supply_mv,
    output logic o_low
);
    logic [12:0] trip_mv;
    // Trip level in millivolts for each threshold code
    always_comb begin
        case (i_thr)
            2'h3: trip_mv = 13'h898;
            2'h2: trip_mv = 13'ha8c;
            2'h1: trip_mv = 13'he74;
            default: trip_mv = 13'h1130;
        endcase
    end
    initial o_low = 1'b0;
    // Unpowered output is junk, so it toggles every cycle
    always @(posedge i_clk_sys) begin
        if (i_power) begin
            o_low <= (i_supply_mv < trip_mv);
        end else begin
            o_low <= ~o_low;
        end
    end
endmodule
`default_nettype wire

// File: test/test_bodc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_bodc_top;
    import bodc_pkg::*;
    logic i_clk_sys, i_resetn, i_por, cmp_low, low_speed_internal_clock, irq_en, gie;
    logic i_wr, i_rd, o_irq, o_bod_reset, o_cmp_enable, o_status;
    logic [7:0] cfg, i_addr, i_wdata, o_rdata, d;
    logic [1:0] o_thr;
    logic [12:0] supply;
    int n_fail, checked;

    bodc_cmp_model cmp (.i_clk_sys(i_clk_sys),
        .i_power(o_cmp_enable | (~i_resetn & cfg[7])), .i_thr(o_thr),
        .i_supply_mv(supply), .o_low(cmp_low));
    bodc_top DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_por(i_por), .i_cmp_low(cmp_low), .i_cfg_byte(cfg),
        .i_sysclk_is_low_speed_internal_clock(low_speed_internal_clock), .i_brownout_irq_enable(irq_en),
        .i_global_irq_enable(gie), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_bod_reset(o_bod_reset), .o_cmp_enable(o_cmp_enable),
        .o_threshold_select(o_thr), .o_supply_low_status(o_status));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    task automatic stop_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write; the next call starts one edge later
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // Read data are valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic ta_wr(input logic [7:0] a, input logic [7:0] v);
        wr(BODC_ADDR_TA, BODC_TA_KEY1);
        wr(BODC_ADDR_TA, BODC_TA_KEY2);
        wr(a, v);
        @(negedge i_clk_sys);
    endtask

    // Bounded wait on status (sel 0) or reset request (sel 1)
    task automatic wait_on(input bit sel, input logic v, input int n);
        logic s;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk_sys);
            #1 s = sel ? o_bod_reset : o_status;
            if (s === v) break;
        end
        check({7'h0, s}, {7'h0, v});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic do_rst(input logic por, input logic [7:0] c);
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        i_por <= por;
        cfg <= c;
        cyc(3);
        i_resetn <= 1'b1;
        i_por <= 1'b0;
    endtask

    task automatic set_supply(input logic [12:0] mv);
        @(posedge i_clk_sys);
        supply <= mv;
    endtask

    // Watchdog well beyond the roughly 28k cycles of the run
    initial begin
        #(90000 * 50);
        n_fail++;
        stop_test();
    end

    initial begin
        {i_resetn, i_wr, i_rd, low_speed_internal_clock, n_fail, checked} = '0;
        {i_por, irq_en, gie} = 3'h7;
        {cfg, i_addr, i_wdata} = {8'hb0, 16'h0};
        supply = 13'h1388;
        cyc(2);
        i_resetn <= 1'b1;
        i_por <= 1'b0;
        check({6'h0, o_thr}, 8'h03);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'hb0);
        rd(BODC_ADDR_CTL2, d);
        check(d, 8'h01);
        rd(8'h10, d);
        check(d, 8'h00);
        // Every threshold code through the unlock
        for (int t = 0; t < 4; t++) begin
            ta_wr(BODC_ADDR_CTL, 8'h8a | 8'(t << 4));
            check({6'h0, o_thr}, 8'(t));
        end
        wr(BODC_ADDR_CTL, 8'h8a);
        wr(BODC_ADDR_TA, BODC_TA_KEY1);
        wr(BODC_ADDR_TA, BODC_TA_KEY2);
        wr(8'h10, 8'h00);
        wr(BODC_ADDR_CTL, 8'h8a);
        cyc(1);
        check({6'h0, o_thr}, 8'h03);
        set_supply(13'hbb8);
        cyc(7000);
        // Short dip is swallowed, a long drop is seen after 32 cycles
        set_supply(13'h7d0);
        cyc(20);
        set_supply(13'hbb8);
        cyc(60);
        check({7'h0, o_status}, 8'h00);
        set_supply(13'h7d0);
        cyc(30);
        check({7'h0, o_status}, 8'h00);
        wait_on(0, 1'b1, 20);
        cyc(3);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'hb9);
        check({7'h0, o_irq}, 8'h01);
        gie <= 1'b0;
        cyc(3);
        check({7'h0, o_irq}, 8'h00);
        gie <= 1'b1;
        irq_en <= 1'b0;
        cyc(3);
        check({7'h0, o_irq}, 8'h00);
        irq_en <= 1'b1;
        // Clear while still low: no new flag
        ta_wr(BODC_ADDR_CTL, 8'hb0);
        cyc(100);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'hb1);
        check({7'h0, o_irq}, 8'h00);
        set_supply(13'hbb8);
        wait_on(0, 1'b0, 60);
        cyc(3);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'hb8);
        // Disabled reads low; after enable, blind until the third slow tick
        ta_wr(BODC_ADDR_CTL, 8'h30);
        cyc(1);
        check({7'h0, o_cmp_enable}, 8'h00);
        set_supply(13'h7d0);
        cyc(100);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'h30);
        ta_wr(BODC_ADDR_CTL, 8'hb0);
        cyc(3900);
        check({7'h0, o_status}, 8'h00);
        wait_on(0, 1'b1, 2400);
        set_supply(13'hbb8);
        wait_on(0, 1'b0, 60);
        // Filter off gives a fast response
        ta_wr(BODC_ADDR_CTL2, 8'h00);
        set_supply(13'h7d0);
        wait_on(0, 1'b1, 8);
        set_supply(13'hbb8);
        wait_on(0, 1'b0, 8);
        ta_wr(BODC_ADDR_CTL2, 8'h01);
        // Slow system clock: filter waits for two slow ticks
        low_speed_internal_clock <= 1'b1;
        set_supply(13'h7d0);
        cyc(100);
        check({7'h0, o_status}, 8'h00);
        wait_on(0, 1'b1, 6000);
        set_supply(13'hbb8);
        wait_on(0, 1'b0, 6000);
        low_speed_internal_clock <= 1'b0;
        // Periodic sampling: a drop is only seen at a sample point
        ta_wr(BODC_ADDR_CTL2, 8'h03);
        set_supply(13'h7d0);
        cyc(100);
        check({7'h0, o_status}, 8'h00);
        wait_on(0, 1'b1, 40000);
        ta_wr(BODC_ADDR_CTL2, 8'h01);
        set_supply(13'hbb8);
        wait_on(0, 1'b0, 60);
        // Reset request, then a cause that survives a warm reset
        ta_wr(BODC_ADDR_CTL, 8'hb4);
        set_supply(13'h7d0);
        wait_on(1, 1'b1, 60);
        set_supply(13'hbb8);
        do_rst(1'b0, 8'hb4);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'hb6);
        do_rst(1'b1, 8'hb4);
        rd(BODC_ADDR_CTL, d);
        check(d, 8'hb4);
        // Flag preset with detection on, no reset select, supply low
        set_supply(13'h7d0);
        do_rst(1'b1, 8'ha0);
        check({6'h0, o_thr}, 8'h02);
        rd(BODC_ADDR_CTL, d);
        check(d & 8'hfe, 8'ha8);
        stop_test();
    end
endmodule
`default_nettype wire
